// >>> ivr_pkg.sv
// Package with constants for the interrupt vector relocation block.
package ivr_pkg;
  // ----------------------------------------------------------------
  // Control register layout
  // ----------------------------------------------------------------
  localparam int unsigned IVR_CHG_BIT = 0;
  localparam int unsigned IVR_SEL_BIT = 1;
  localparam logic [7:0] IVR_CTRL_RESET = 8'h00;
  localparam int unsigned IVR_WINDOW_CYC = 4;
  // ----------------------------------------------------------------
  // Address map in words
  // ----------------------------------------------------------------
  localparam logic [11:0] IVR_APP_RESET_ADDR = 12'h000;
  localparam logic [11:0] IVR_APP_VEC_BASE = 12'h000;
  localparam logic [11:0] IVR_FLASH_WORDS = 12'hfff;
  // Boot start for each boot size fuse code 0..3; code 0 is the largest section.
  localparam logic [11:0] IVR_BOOT_START_0 = 12'hc00;
  localparam logic [11:0] IVR_BOOT_START_1 = 12'he00;
  localparam logic [11:0] IVR_BOOT_START_2 = 12'hf00;
  localparam logic [11:0] IVR_BOOT_START_3 = 12'hf80;
  localparam logic IVR_FUSE_PROGRAMMED = 1'b0;
  localparam int unsigned IVR_NUM_VEC = 19;
endpackage

// >>> ivr_window.sv
// Change-enable window timer for the vector select bit.
`timescale 1ns/100ps
module ivr_window
  import ivr_pkg::*;
#(
  parameter int unsigned WINDOW_CYC = IVR_WINDOW_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_open,
  input wire logic i_close,
  output logic o_active
);
  logic [3:0] cnt_r;

  // The window closes after its count or on the select write, whichever first.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 4'h0;
    end else if (i_open) begin
      cnt_r <= 4'(WINDOW_CYC);
    end else if (i_close) begin
      cnt_r <= 4'h0;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  assign o_active = (cnt_r != 4'h0);
endmodule

// >>> ivr_top.sv
// Interrupt vector relocation control with timed select change.
`timescale 1ns/100ps
// How it works
// - With select clear, vectors start at the beginning of program flash.
// - With select set, vectors start at the boot section start chosen by the boot size fuses.
// - A select write is taken only within four cycles after the change-enable bit is written to one.
// - Interrupts are masked from the cycle change-enable sets until the instruction after the select write ends.
// - With no select write, the mask lasts five cycles and then drops.
// - The automatic mask never touches the global interrupt enable flag.
// - Change-enable clears itself after five cycles or at the select write, whichever first.
// - Vectors in boot with the application lock programmed block interrupts while running in the application.
// - Vectors in application with the loader lock programmed block interrupts while running in the loader.
// - Fuse unprogrammed, 2K boot, select set gives reset at 000 and vectors c01 to c12.
// - Fuse programmed, 2K boot, select clear gives reset at c00 and vectors 001 to 012.
// - Fuse programmed, 2K boot, select set gives reset at c00 and vectors c01 to c12.
// - A relocated vector address is its table offset plus the boot start.
// - Boot reset fuse value one means unprogrammed and zero means programmed.
module ivr_top
  import ivr_pkg::*;
#(
  parameter int unsigned WINDOW_CYC = IVR_WINDOW_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ctrl_we,
  input wire logic [7:0] i_ctrl_wdata,
  input wire logic i_instr_done,
  input wire logic [1:0] i_boot_size_fuses,
  input wire logic i_boot_reset_fuse,
  input wire logic i_app_section_boot_lock,
  input wire logic i_loader_section_boot_lock,
  input wire logic [11:0] i_pc,
  input wire logic [4:0] i_vec_num,
  output logic [7:0] o_ctrl_rdata,
  output logic o_irq_block,
  output logic [11:0] o_reset_addr,
  output logic [11:0] o_vec_addr
);
  // ----------------------------------------------------------------
  // Change window
  // ----------------------------------------------------------------
  logic vector_table_select_r;
  logic win_active;
  logic open_req;
  logic sel_write;
  logic hold_r;
  logic [11:0] boot_start;
  logic vec_in_boot;
  logic in_boot_code;
  logic lock_block;

  assign open_req = i_ctrl_we && i_ctrl_wdata[IVR_CHG_BIT];
  // A write with change-enable zero inside the window is the select write.
  assign sel_write = i_ctrl_we && !i_ctrl_wdata[IVR_CHG_BIT] && win_active;

  ivr_window #(
    .WINDOW_CYC(WINDOW_CYC)
  ) u_window (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_open(open_req),
    .i_close(sel_write),
    .o_active(win_active)
  );

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vector_table_select_r <= IVR_CTRL_RESET[IVR_SEL_BIT];
    end else if (sel_write) begin
      vector_table_select_r <= i_ctrl_wdata[IVR_SEL_BIT];
    end
    // Writes outside the window leave the select untouched.
  end

  // Keeps the mask over the instruction after the select write.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_r <= 1'b0;
    end else if (sel_write) begin
      hold_r <= 1'b1;
    end else if (i_instr_done) begin
      hold_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------
  always_comb begin
    unique case (i_boot_size_fuses)
      2'd0: boot_start = IVR_BOOT_START_0;
      2'd1: boot_start = IVR_BOOT_START_1;
      2'd2: boot_start = IVR_BOOT_START_2;
      2'd3: boot_start = IVR_BOOT_START_3;
    endcase
  end

  assign vec_in_boot = vector_table_select_r;
  assign in_boot_code = (i_pc >= boot_start);
  assign lock_block = (vec_in_boot && !in_boot_code && i_app_section_boot_lock == IVR_FUSE_PROGRAMMED) ||
    (!vec_in_boot && in_boot_code && i_loader_section_boot_lock == IVR_FUSE_PROGRAMMED);

  // The block output only gates dispatch; the core's global enable stays as software left it.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq_block <= 1'b1;
    end else begin
      // Opening the window masks at once; the window itself covers the four cycles.
      o_irq_block <= open_req || (win_active && !sel_write) || sel_write ||
        (hold_r && !i_instr_done) || lock_block;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reset_addr <= IVR_APP_RESET_ADDR;
      o_vec_addr <= IVR_APP_VEC_BASE;
      o_ctrl_rdata <= IVR_CTRL_RESET;
    end else begin
      o_reset_addr <= (i_boot_reset_fuse == IVR_FUSE_PROGRAMMED) ? boot_start : IVR_APP_RESET_ADDR;
      o_vec_addr <= (vec_in_boot ? boot_start : IVR_APP_VEC_BASE) + {7'h00, i_vec_num};
      o_ctrl_rdata <= {6'h00, (sel_write ? i_ctrl_wdata[IVR_SEL_BIT] : vector_table_select_r),
        (open_req || (win_active && !sel_write))};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mask_on_open;
    @(posedge i_clk) disable iff (!i_arst_n) open_req |=> o_irq_block;
  endproperty
  a_mask_on_open: assert property (p_mask_on_open) else $error("mask not set on change enable");

  property p_window_expiry;
    @(posedge i_clk) disable iff (!i_arst_n)
      (open_req && WINDOW_CYC == 4) ##1 (!i_ctrl_we)[*4] |=> !win_active;
  endproperty
  a_window_expiry: assert property (p_window_expiry) else $error("window open past four cycles");

  property p_late_write_ignored;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_ctrl_we && !win_active && !i_ctrl_wdata[IVR_CHG_BIT]) |=> $stable(vector_table_select_r);
  endproperty
  a_late_write_ignored: assert property (p_late_write_ignored) else $error("select changed outside window");

  property p_sel_taken;
    @(posedge i_clk) disable iff (!i_arst_n)
      sel_write |=> vector_table_select_r == $past(i_ctrl_wdata[IVR_SEL_BIT]);
  endproperty
  a_sel_taken: assert property (p_sel_taken) else $error("select write lost");

  property p_sel_closes;
    @(posedge i_clk) disable iff (!i_arst_n) sel_write |=> !win_active;
  endproperty
  a_sel_closes: assert property (p_sel_closes) else $error("window not closed by select write");

  property p_vec_base;
    @(posedge i_clk) disable iff (!i_arst_n)
      ##1 1'b1 |-> o_vec_addr == ($past(vector_table_select_r) ? $past(boot_start) : IVR_APP_VEC_BASE)
        + {7'h00, $past(i_vec_num)};
  endproperty
  a_vec_base: assert property (p_vec_base) else $error("vector address wrong");

  property p_reset_addr;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_boot_reset_fuse && i_boot_size_fuses == 2'd0) |=> o_reset_addr == IVR_APP_RESET_ADDR;
  endproperty
  a_reset_addr: assert property (p_reset_addr) else $error("reset address wrong");

  property p_lock_block;
    @(posedge i_clk) disable iff (!i_arst_n) lock_block |=> o_irq_block;
  endproperty
  a_lock_block: assert property (p_lock_block) else $error("lock did not block interrupts");

  property p_hold_after_sel;
    @(posedge i_clk) disable iff (!i_arst_n) (sel_write ##1 !i_instr_done) |=> o_irq_block;
  endproperty
  a_hold_after_sel: assert property (p_hold_after_sel) else $error("mask dropped before next instruction");

  // The mask must stand on every cycle that the window is open.
  property p_mask_in_window;
    @(posedge i_clk) disable iff (!i_arst_n) win_active |=> o_irq_block;
  endproperty
  a_mask_in_window: assert property (p_mask_in_window) else $error("mask missing inside window");

  // An unused window must release the mask, or the core would starve.
  property p_mask_expires;
    @(posedge i_clk) disable iff (!i_arst_n)
      (open_req && WINDOW_CYC == 4 && !hold_r) ##1 (!i_ctrl_we && !lock_block)[*5] |=> !o_irq_block;
  endproperty
  a_mask_expires: assert property (p_mask_expires) else $error("mask held past unused window");

  property p_hold_clears;
    @(posedge i_clk) disable iff (!i_arst_n)
      (hold_r && i_instr_done && !win_active && !open_req && !lock_block) |=> !o_irq_block;
  endproperty
  a_hold_clears: assert property (p_hold_clears) else $error("mask kept after next instruction");

  property p_chg_read;
    @(posedge i_clk) disable iff (!i_arst_n) open_req |=> o_ctrl_rdata[IVR_CHG_BIT];
  endproperty
  a_chg_read: assert property (p_chg_read) else $error("change enable not shown after write");

  property p_chg_clear_on_sel;
    @(posedge i_clk) disable iff (!i_arst_n) sel_write |=> !o_ctrl_rdata[IVR_CHG_BIT];
  endproperty
  a_chg_clear_on_sel: assert property (p_chg_clear_on_sel) else $error("change enable kept after select");

  property p_sel_read;
    @(posedge i_clk) disable iff (!i_arst_n) 1'b1 |=> o_ctrl_rdata[IVR_SEL_BIT] == vector_table_select_r;
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("read select differs from stored select");

  property p_reset_boot;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_boot_reset_fuse == IVR_FUSE_PROGRAMMED && i_boot_size_fuses == 2'd0) |=> o_reset_addr == IVR_BOOT_START_0;
  endproperty
  a_reset_boot: assert property (p_reset_boot) else $error("boot reset address wrong");

  property p_vec_app;
    @(posedge i_clk) disable iff (!i_arst_n)
      (!vector_table_select_r && i_vec_num == 5'd1) |=> o_vec_addr == 12'h001;
  endproperty
  a_vec_app: assert property (p_vec_app) else $error("application vector address wrong");

  property p_vec_boot_2k;
    @(posedge i_clk) disable iff (!i_arst_n)
      (vector_table_select_r && i_boot_size_fuses == 2'd0 && i_vec_num == 5'd18) |=> o_vec_addr == 12'hc12;
  endproperty
  a_vec_boot_2k: assert property (p_vec_boot_2k) else $error("boot vector address wrong");
endmodule

// >>> ivr_core_model.sv
// Core model that writes the control register and retires instructions.
`timescale 1ns/100ps
module ivr_core_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_sel,
  input wire logic [2:0] i_gap,
  output logic o_ctrl_we,
  output logic [7:0] o_ctrl_wdata,
  output logic o_instr_done
);
  initial begin
    o_ctrl_we = 1'b0;
    o_ctrl_wdata = 8'h00;
    o_instr_done = 1'b0;
  end
  // A gap of zero skips the select write; a gap above four lands outside the window.
  always begin
    @(posedge i_clk iff i_go);
    #1 o_ctrl_we = 1'b1;
    o_ctrl_wdata = 8'h01;
    @(posedge i_clk);
    #1 o_ctrl_we = 1'b0;
    o_ctrl_wdata = 8'hfe;
    if (i_gap != 3'h0) begin
      repeat (i_gap - 3'h1) @(posedge i_clk);
      #1 o_ctrl_we = 1'b1;
      o_ctrl_wdata = {6'h00, i_sel, 1'b0};
      @(posedge i_clk);
      #1 o_ctrl_we = 1'b0;
      o_ctrl_wdata = ~o_ctrl_wdata;
      o_instr_done = 1'b1;
      @(posedge i_clk);
      #1 o_instr_done = 1'b0;
    end
  end
endmodule

// >>> tb_ivr_top.sv
// Self-checking testbench for the interrupt vector relocation block.
`timescale 1ns/100ps
module tb_ivr_top
  import ivr_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic go = 1'b0;
  logic sel = 1'b0;
  logic [2:0] gap = 3'h0;
  logic we, done;
  logic [7:0] wd, rd;
  logic [1:0] sz = 2'h0;
  logic fuse = 1'b1;
  logic alock = 1'b1;
  logic llock = 1'b1;
  logic [11:0] pc = 12'h000;
  logic [4:0] vn = 5'h01;
  logic blk;
  logic [11:0] ra, va, st;
  logic exp_sel = 1'b0;
  logic [31:0] seed = 32'hd92e;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 i_clk = ~i_clk;
  ivr_core_model ivr_core_model_i (.i_clk(i_clk), .i_go(go), .i_sel(sel), .i_gap(gap),
    .o_ctrl_we(we), .o_ctrl_wdata(wd), .o_instr_done(done));
  ivr_top ivr_top_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ctrl_we(we), .i_ctrl_wdata(wd),
    .i_instr_done(done), .i_boot_size_fuses(sz), .i_boot_reset_fuse(fuse),
    .i_app_section_boot_lock(alock), .i_loader_section_boot_lock(llock), .i_pc(pc),
    .i_vec_num(vn), .o_ctrl_rdata(rd), .o_irq_block(blk), .o_reset_addr(ra), .o_vec_addr(va));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [11:0] boot_start(input logic [1:0] code);
    case (code)
      2'h0: return IVR_BOOT_START_0;
      2'h1: return IVR_BOOT_START_1;
      2'h2: return IVR_BOOT_START_2;
      default: return IVR_BOOT_START_3;
    endcase
  endfunction
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (!ok) begin
      failures++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Relocation sequence followed by random placement checks
  // ----------------------------------------------------------------
  task automatic run(input logic s, input logic [2:0] g);
    alock = 1'b1;
    llock = 1'b1;
    sel = s;
    gap = g;
    go = 1'b1;
    @(posedge i_clk);
    #1 go = 1'b0;
    @(posedge i_clk);
    #2 chk(blk === 1'b1 && rd[IVR_CHG_BIT] === 1'b1, "mask or enable not set");
    if (g >= 3'h1 && g <= 3'h4) exp_sel = s;
    repeat ((g == 3'h0) ? 2 : g) @(posedge i_clk);
    #2 if (g == 3'h0) chk(blk === 1'b1 && rd === 8'h01, "window closed early");
    else chk(rd === {6'h00, exp_sel, 1'b0} && blk === (g <= 3'h4), "select write wrong");
    repeat (8) @(posedge i_clk);
    #2 chk(blk === 1'b0 && rd === {6'h00, exp_sel, 1'b0}, "mask or enable stuck");
    repeat (20) begin
      @(posedge i_clk);
      #1 sz = 2'(rnd());
      {fuse, alock, llock} = 3'(rnd());
      pc = 12'(rnd());
      vn = 5'(rnd() % 18 + 1);
      st = boot_start(sz);
      @(posedge i_clk);
      #1 chk(ra === ((fuse === IVR_FUSE_PROGRAMMED) ? st : IVR_APP_RESET_ADDR), "reset addr");
      chk(va === (exp_sel ? st : IVR_APP_VEC_BASE) + {7'h00, vn}, "vector addr");
      chk(blk === ((exp_sel && !alock && pc < st) || (!exp_sel && !llock && pc >= st)), "lock block");
    end
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    chk(rd === IVR_CTRL_RESET && blk === 1'b1, "reset value");
    run(1'b1, 3'h1);
    run(1'b0, 3'h4);
    run(1'b1, 3'h0);
    run(1'b1, 3'h6);
    run(1'b1, 3'h2);
    i_arst_n = 1'b0;
    @(posedge i_clk);
    #1 chk(blk === 1'b1 && rd === IVR_CTRL_RESET && va === IVR_APP_VEC_BASE, "reset state");
    repeat (2) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    exp_sel = 1'b0;
    run(1'b1, 3'h3);
    give_verdict();
  end
endmodule
